/* File: bench/adc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Host serial controller: frames readouts, clocks in slave mode
module adc_host_model #(
   parameter int SLAVE_HALF = 20
) (
   // Clock
   input  wire logic clk_sys,
   // Device side lines
   input  wire logic masterMode,
   input  wire logic dataLine,
   input  wire logic sclkLine,
   output logic      csN,
   output logic      sclkIn
);
   // Idle: deselected, clock parked high
   initial begin
      csN = 1'b1;
      sclkIn = 1'b1;
   end

   // Select line control
   task automatic setCs(input logic v);
      @(negedge clk_sys) csN = v;
   endtask

   // One readout; select stays low afterwards
   task automatic readWord(output logic [23:0] w, output int tRdy, output int tEdge,
                           output int hiW);
      int cnt;
      w = '0;
      tEdge = 0;
      hiW = 0;
      tRdy = 2;
      setCs(1'b0);
      // Skip the cycles before the driver turns on
      repeat (2) @(negedge clk_sys);
      while (dataLine !== 1'b0 && tRdy < 5000) begin
         @(negedge clk_sys);
         tRdy++;
      end
      for (int b = 23; b >= 0; b--) begin
         cnt = 0;
         if (masterMode) begin
            while (sclkLine !== 1'b0 && cnt < 1000) begin
               @(negedge clk_sys);
               cnt++;
            end
            if (b == 23) tEdge = cnt;
            if (b == 22) hiW = cnt;
            // Bit stands from the fall; last rise already drives the line high
            w[b] = dataLine;
            while (sclkLine !== 1'b1 && cnt < 2000) begin
               @(negedge clk_sys);
               cnt++;
            end
         end else begin
            repeat (SLAVE_HALF) @(negedge clk_sys);
            sclkIn = 1'b0;
            repeat (SLAVE_HALF) @(negedge clk_sys);
            sclkIn = 1'b1;
            w[b] = dataLine;
         end
      end
   endtask
endmodule

`default_nettype wire

/* File: bench/test_adc_serial_readout_port.sv */
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Self-checking bench for the serial readout port
module test_adc_serial_readout_port;
   import adc_readout_pkg::*;
   localparam int CONV = 200;
   localparam int HALF = 4;
   logic                clk_sys = 1'b0;
   logic                rstn = 1'b0;
   logic                masterMode = 1'b0;
   logic                channel_select = 1'b0;
   logic [RESULT_W-1:0] sampleCh1 = '0;
   logic [RESULT_W-1:0] sampleCh2 = '0;
   logic                csN;
   logic                sclkIn;
   logic                powerDown;
   logic                lastDrv = 1'b1;
   logic                dataLine;
   logic                sclkLine;
   serial_pins_t        pins;
   int                  n_mismatch = 0;
   int                  compares = 0;
   int                  cycles = 0;
   int                  seed = 97;

   // Clock
   always #2.5 clk_sys = ~clk_sys;

   // Released data line shows the inverse of its last level
   always @(posedge clk_sys) if (pins.dataOutEn) lastDrv <= pins.dataOut;
   assign dataLine = pins.dataOutEn ? pins.dataOut : ~lastDrv;
   assign sclkLine = pins.sclkOutEn ? pins.sclkOut : sclkIn;

   adc_serial_readout_port #(.CONV_CYCLES(CONV), .HALF_CYCLES(HALF)) i_dut (
      .clk_sys(clk_sys), .rstn(rstn), .csN(csN), .sclkIn(sclkIn), .masterMode(masterMode),
      .channel_select(channel_select), .sampleCh1(sampleCh1), .sampleCh2(sampleCh2),
      .pins(pins), .powerDown(powerDown));

   adc_host_model #(.SLAVE_HALF(20)) i_host (
      .clk_sys(clk_sys), .masterMode(masterMode), .dataLine(dataLine),
      .sclkLine(sclkLine), .csN(csN), .sclkIn(sclkIn));

   // Comparison and report
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // Main sequence
   initial begin
      logic [23:0] w;
      logic [23:0] exp;
      int          tRdy;
      int          tEdge;
      int          hiW;
      repeat (4) @(negedge clk_sys);
      check("float in reset", pins.dataOutEn, 0);
      check("power down idle", powerDown, 1);
      rstn = 1'b1;
      for (int i = 0; i < 6; i++) begin
         masterMode = i[0];
         channel_select = i[1];
         sampleCh1 = (i == 0) ? 24'hFF_FFFF : 24'($random(seed));
         sampleCh2 = (i == 2) ? 24'h00_0000 : 24'($random(seed));
         exp = channel_select ? sampleCh2 : sampleCh1;
         i_host.readWord(w, tRdy, tEdge, hiW);
         check("driving", pins.dataOutEn, 1);
         check("running", powerDown, 0);
         check("clock drive", pins.sclkOutEn, masterMode);
         check("word", w, exp);
         check("ready time", tRdy >= CONV - 2 && tRdy <= CONV + 3, 1);
         if (masterMode) begin
            check("first edge", tEdge >= HALF && tEdge <= 3 * HALF, 1);
            check("high phase", hiW, HALF);
         end
         repeat (4) @(negedge clk_sys);
         check("high after last clock", dataLine, 1);
         i_host.setCs(1'b1);
         repeat (2) @(negedge clk_sys);
         check("released", pins.dataOutEn, 0);
         check("power down", powerDown, 1);
      end
      // Abort mid conversion, then a full readout restarts the count
      i_host.setCs(1'b0);
      repeat (CONV / 2) @(negedge clk_sys);
      check("driving early", pins.dataOutEn, 1);
      i_host.setCs(1'b1);
      repeat (2) @(negedge clk_sys);
      check("abort float", pins.dataOutEn, 0);
      masterMode = 1'b0;
      i_host.readWord(w, tRdy, tEdge, hiW);
      check("restart time", tRdy >= CONV - 2 && tRdy <= CONV + 3, 1);
      check("restart word", w, channel_select ? sampleCh2 : sampleCh1);
      finish_test();
   end
endmodule

`default_nettype wire

/* File: src/adc_conv_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// =========================================================
// Conversion engine stand-in: pulses a fresh result every period
module adc_conv_timer #(
   parameter int CONV_CYCLES = adc_readout_pkg::CONV_CYC
) (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rstn,
   // Control
   input  wire logic                           running,
   input  wire logic [adc_readout_pkg::RESULT_W-1:0] sample,
   // Result
   output adc_readout_pkg::conv_result_t       result
);
   import adc_readout_pkg::*;

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   conv_result_t     res_r;
   conv_result_t     res_nxt;

   // Period counter, restarts when powered down
   always_comb begin
      cnt_nxt       = cnt_r;
      res_nxt       = res_r;
      res_nxt.valid = 1'b0;
      if (!running) begin
         cnt_nxt = '0;                                      // RQ8
      end else if (cnt_r == CNT_W'(CONV_CYCLES - 1)) begin
         cnt_nxt       = '0;
         res_nxt.valid = 1'b1;                              // RQ1
         res_nxt.code  = sample;
      end else begin
         cnt_nxt = cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= '0;
         res_r <= '{valid: 1'b0, code: RESULT_RST};
      end else begin
         cnt_r <= cnt_nxt;
         res_r <= res_nxt;
      end
   end

   assign result = res_r;

   a_conv_period: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ1
      res_r.valid |=> !res_r.valid [*8])
      else $error("result pulses too close");

endmodule
`default_nettype wire

/* File: src/adc_readout_pkg.sv */
package adc_readout_pkg;

   // =========================================================
   // Widths
   localparam int RESULT_W = 24;
   localparam int CNT_W    = 24;

   // =========================================================
   // Timing, system clock 200 MHz
   localparam int CLK_PERIOD_PS        = 5000;
   localparam int CRYSTAL_PERIOD_PS    = 30_517_600;   // 30.5176 us
   localparam int CONVERSION_PERIOD_US = 50_540;       // 50.54 ms
   localparam int HALF_XTAL_CYC  = CRYSTAL_PERIOD_PS / 2 / CLK_PERIOD_PS;
   localparam int CONV_CYC       = CONVERSION_PERIOD_US * 1000 / (CLK_PERIOD_PS / 1000);
   // Wait from data low to first falling clock edge: one half period
   localparam int FIRST_EDGE_CYC = HALF_XTAL_CYC;

   // =========================================================
   // Reset values
   localparam logic [RESULT_W-1:0] RESULT_RST = 24'h80_0000;  // Offset binary zero

   // =========================================================
   // Carriers
   typedef struct packed {
      logic                dataOut;
      logic                dataOutEn;
      logic                sclkOut;
      logic                sclkOutEn;
   } serial_pins_t;

   typedef struct packed {
      logic                valid;
      logic [RESULT_W-1:0] code;
   } conv_result_t;

endpackage

/* File: src/adc_serial_readout_port.sv */
`timescale 1ns/1ps
`default_nettype none

//
// Behaviour
// [RQ1] New result every conversion period
// [RQ2] Data changes after falling clock edge
// [RQ3] Chip select low enables data driver
// [RQ4] Chip select high floats data line
// [RQ5] Host holds select until clock idle
// [RQ6] Data line high after last clock
// [RQ7] Master first edge within half-three halves
// [RQ8] Convert while selected, else power down
// [RQ9] Master clock phases half crystal period
// [RQ10] Offset binary, most significant bit first
//
module adc_serial_readout_port #(
   parameter int CONV_CYCLES = adc_readout_pkg::CONV_CYC,
   parameter int HALF_CYCLES = adc_readout_pkg::HALF_XTAL_CYC
) (
   // Clock and reset
   input  wire logic                                 clk_sys,
   input  wire logic                                 rstn,
   // Host side pins
   input  wire logic                                 csN,
   input  wire logic                                 sclkIn,
   input  wire logic                                 masterMode,
   input  wire logic                                 channel_select,
   // Converter sample input, offset binary
   input  wire logic [adc_readout_pkg::RESULT_W-1:0] sampleCh1,
   input  wire logic [adc_readout_pkg::RESULT_W-1:0] sampleCh2,
   // Pin drivers
   output adc_readout_pkg::serial_pins_t             pins,
   output logic                                      powerDown
);
   import adc_readout_pkg::*;

   typedef enum {IDLE, WAIT_DATA, FIRST, SHIFT, DONE} rd_state_t;

   // =========================================================
   // Conversion engine
   conv_result_t               convRes;
   logic [RESULT_W-1:0]        sampleSel;
   logic                       running;

   assign running   = !csN;                                 // RQ8
   assign sampleSel = channel_select ? sampleCh2 : sampleCh1;

   adc_conv_timer #(
      .CONV_CYCLES (CONV_CYCLES)
   ) u_timer (
      .clk_sys (clk_sys),
      .rstn    (rstn),
      .running (running),
      .sample  (sampleSel),
      .result  (convRes)
   );

   // =========================================================
   // Readout state
   rd_state_t           st_r,     st_nxt;
   logic [RESULT_W-1:0] shReg_r,  shReg_nxt;
   logic [5:0]          bitCnt_r, bitCnt_nxt;
   logic [CNT_W-1:0]    div_r,    div_nxt;
   logic                sclkPrev_r;
   serial_pins_t        pins_r,   pins_nxt;
   logic                pd_r;
   logic                fallSlave;
   logic                riseSlave;
   logic                halfTick;

   // Falling and rising edge of host clock
   assign fallSlave = sclkPrev_r && !sclkIn;                // RQ2
   assign riseSlave = !sclkPrev_r && sclkIn;
   assign halfTick  = (div_r == CNT_W'(HALF_CYCLES - 1));

   // Next state of the shifter and pins
   always_comb begin
      st_nxt     = st_r;
      shReg_nxt  = shReg_r;
      bitCnt_nxt = bitCnt_r;
      div_nxt    = halfTick ? '0 : div_r + 1'b1;
      pins_nxt   = pins_r;
      pins_nxt.sclkOutEn = masterMode && !csN;
      if (csN) begin
         st_nxt             = IDLE;
         pins_nxt.dataOutEn = 1'b0;                         // RQ4
         pins_nxt.dataOut   = 1'b1;
         pins_nxt.sclkOut   = 1'b1;
      end else begin
         pins_nxt.dataOutEn = 1'b1;                         // RQ3
         case (st_r)
            IDLE: begin
               pins_nxt.dataOut = 1'b1;
               st_nxt           = WAIT_DATA;
            end
            WAIT_DATA: begin
               if (convRes.valid) begin
                  shReg_nxt        = convRes.code;          // RQ10
                  bitCnt_nxt       = 6'(RESULT_W);
                  div_nxt          = '0;
                  pins_nxt.dataOut = 1'b0;                  // Ready flag
                  st_nxt           = masterMode ? FIRST : SHIFT;
               end
            end
            FIRST: begin
               if (halfTick) begin
                  pins_nxt.sclkOut = 1'b0;                  // RQ7
                  pins_nxt.dataOut = shReg_r[RESULT_W-1];
                  shReg_nxt        = {shReg_r[RESULT_W-2:0], 1'b0};
                  bitCnt_nxt       = bitCnt_r - 1'b1;
                  st_nxt           = SHIFT;
               end
            end
            SHIFT: begin
               if (masterMode) begin
                  if (halfTick) begin
                     pins_nxt.sclkOut = !pins_r.sclkOut;    // RQ9
                     if (pins_r.sclkOut && bitCnt_r != '0) begin
                        pins_nxt.dataOut = shReg_r[RESULT_W-1]; // RQ2
                        shReg_nxt  = {shReg_r[RESULT_W-2:0], 1'b0};
                        bitCnt_nxt = bitCnt_r - 1'b1;
                     end else if (!pins_r.sclkOut && bitCnt_r == '0) begin
                        pins_nxt.dataOut = 1'b1;            // RQ6
                        st_nxt           = DONE;
                     end
                  end
               end else if (fallSlave && bitCnt_r != '0) begin
                  pins_nxt.dataOut = shReg_r[RESULT_W-1];   // RQ2
                  shReg_nxt  = {shReg_r[RESULT_W-2:0], 1'b0};
                  bitCnt_nxt = bitCnt_r - 1'b1;
               end else if (riseSlave && bitCnt_r == '0) begin
                  pins_nxt.dataOut = 1'b1;                  // RQ6
                  st_nxt           = DONE;
               end
            end
            DONE: begin
               pins_nxt.dataOut = 1'b1;
               pins_nxt.sclkOut = 1'b1;
               st_nxt           = WAIT_DATA;
            end
            default: st_nxt = IDLE;
         endcase
      end
   end

   // Register stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_r       <= IDLE;
         shReg_r    <= RESULT_RST;
         bitCnt_r   <= '0;
         div_r      <= '0;
         sclkPrev_r <= 1'b1;
         pins_r     <= '{dataOut: 1'b1, dataOutEn: 1'b0, sclkOut: 1'b1, sclkOutEn: 1'b0};
         pd_r       <= 1'b1;
      end else begin
         st_r       <= st_nxt;
         shReg_r    <= shReg_nxt;
         bitCnt_r   <= bitCnt_nxt;
         div_r      <= div_nxt;
         sclkPrev_r <= sclkIn;
         pins_r     <= pins_nxt;
         pd_r       <= csN;                                 // RQ8
      end
   end

   assign pins      = pins_r;
   assign powerDown = pd_r;

   // =========================================================
   // Checks helper: cycles spent waiting for the first master edge
   logic [CNT_W-1:0] firstWait_r;
   logic [CNT_W-1:0] firstWait_nxt;

   // Count while the ready flag waits for the first clock fall
   always_comb begin
      firstWait_nxt = '0;
      if (st_r == FIRST) begin
         firstWait_nxt = firstWait_r + 1'b1;
      end
   end

   // Wait counter register
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         firstWait_r <= '0;
      end else begin
         firstWait_r <= firstWait_nxt;
      end
   end

   // =========================================================
   // Checks
   a_drive_on_select: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ3
      $fell(csN) |=> pins_r.dataOutEn)
      else $error("data not driven after select");
   a_float_on_deselect: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ4
      $rose(csN) |=> !pins_r.dataOutEn)
      else $error("data not released after deselect");
   a_power_follows_cs: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ8
      ##1 pd_r == $past(csN))
      else $error("power down not following select");
   a_master_first_edge: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
      (masterMode && st_r == FIRST) |-> firstWait_r < CNT_W'(3 * HALF_CYCLES))
      else $error("first master edge late");
   a_master_first_min: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ7
      ($fell(pins_r.sclkOut) && $past(st_r) == FIRST)
      |-> firstWait_r >= CNT_W'(HALF_CYCLES))
      else $error("first master edge early");
   a_data_high_done: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ6
      (st_r == DONE) |-> pins_r.dataOut)
      else $error("data not high after readout");
   a_slave_change_fall: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ2
      (!masterMode && st_r == SHIFT && $past(st_r) == SHIFT
       && $changed(pins_r.dataOut) && !csN)
      |-> $past(fallSlave) || $past(riseSlave))
      else $error("data changed off clock edge");
   a_msb_first: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ10
      (st_r == WAIT_DATA && convRes.valid && !csN && !masterMode)
      |=> bitCnt_r == 6'(RESULT_W) && shReg_r == $past(convRes.code))
      else $error("result not loaded whole");
   a_master_half: assert property (@(posedge clk_sys) disable iff (!rstn) // RQ9
      (masterMode && st_r == SHIFT && $changed(pins_r.sclkOut))
      |-> $past(halfTick))
      else $error("master clock phase wrong");

   c_slave_read:  cover property (@(posedge clk_sys) !masterMode && st_r == DONE);
   c_master_read: cover property (@(posedge clk_sys) masterMode && st_r == DONE);
   c_power_down:  cover property (@(posedge clk_sys) $rose(pd_r));
   c_channel_two: cover property (@(posedge clk_sys) convRes.valid && channel_select);

endmodule
`default_nettype wire
